// ===== logic/sbrg_defines.svh
`ifndef SBRG_DEFINES_SVH
`define SBRG_DEFINES_SVH

// Register index on the plain port
`define SBRG_OFF_TX_CTRL      3'h0
`define SBRG_OFF_RX_CTRL      3'h1
`define SBRG_OFF_RATE_CTRL    3'h2
`define SBRG_OFF_DIV_HIGH     3'h3
`define SBRG_OFF_DIV_LOW      3'h4
`define SBRG_OFF_GEN_STATUS   3'h5

// Reset values
`define SBRG_RST_TX_CTRL      8'h02
`define SBRG_RST_RX_CTRL      8'h00
`define SBRG_RST_RATE_CTRL    8'h40
`define SBRG_RST_DIV          8'h00

// Software-writable bits; the rest read back their reset value
`define SBRG_WMASK_TX_CTRL    8'hFD
`define SBRG_WMASK_RX_CTRL    8'hF8
`define SBRG_WMASK_RATE_CTRL  8'hBB

// Field positions
`define SBRG_BIT_MASTER       7
`define SBRG_BIT_SYNC         4
`define SBRG_BIT_HIGH_SPEED   2
`define SBRG_BIT_PORT_ENABLE  7
`define SBRG_BIT_RX_INVERT    5
`define SBRG_BIT_WIDE_DIV     3

// Prescale lengths: quarter-bit period is prescale * (n + 1) clocks
`define SBRG_PRESC_DIV64      5'h10
`define SBRG_PRESC_DIV16      5'h04
`define SBRG_PRESC_DIV4       5'h01

// Quarter-bit phases at which the line is sampled
`define SBRG_PHASE_SAMPLE_A   2'h1
`define SBRG_PHASE_SAMPLE_B   2'h2
`define SBRG_PHASE_DECIDE     2'h3

`define SBRG_LINE_IDLE        1'b1

`endif

// ===== logic/sbrg_majority.sv
`timescale 1ns/1ps
`include "sbrg_defines.svh"

module sbrg_majority
  import sbrg_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  input  wire logic line_i,
  input  wire logic sample_a_i,
  input  wire logic sample_b_i,
  input  wire logic decide_i,
  output logic      level_o
);

  sbrg_vote_t vote_ff;
  sbrg_vote_t nxt_vote;

  always_comb
  begin
    nxt_vote = vote_ff;
    if (sample_a_i)
    begin
      nxt_vote.sample_a = line_i;
    end
    if (sample_b_i)
    begin
      nxt_vote.sample_b = line_i;
    end
    // Third sample is the live line; two of three decide
    if (decide_i)
    begin
      nxt_vote.level = (vote_ff.sample_a & vote_ff.sample_b) |
                       (vote_ff.sample_a & line_i) |
                       (vote_ff.sample_b & line_i);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      vote_ff <= '{sample_a: `SBRG_LINE_IDLE, sample_b: `SBRG_LINE_IDLE,
                   level: `SBRG_LINE_IDLE};
    end
    else
    begin
      vote_ff <= nxt_vote;
    end
  end

  assign level_o = vote_ff.level;

endmodule : sbrg_majority

// ===== logic/sbrg_pkg.sv
package sbrg_pkg;

  typedef struct packed {
    logic [7:0]  tx_ctrl;
    logic [7:0]  rx_ctrl;
    logic [7:0]  rate_ctrl;
    logic [7:0]  div_high;
    logic [7:0]  div_low;
    logic [4:0]  presc;
    logic [15:0] timer;
    logic [1:0]  phase;
    logic [7:0]  rdata;
    logic        bit_tick;
    logic        quarter_tick;
    logic        bit_clk;
    logic        bit_clk_oe;
  } sbrg_state_t;

  typedef struct packed {
    logic sample_a;
    logic sample_b;
    logic level;
  } sbrg_vote_t;

endpackage : sbrg_pkg

// ===== logic/sbrg_top.sv
// Operation
// - All rate ticks are counted from the system clock alone.
// - Receive line sampled three times per bit, level set by majority.
// - Divisor n is high byte concatenated with low byte, unsigned.
// - Async, 8-bit, low speed: rate is clock over 64 times (n+1).
// - Async, 16-bit, low speed: rate is clock over 16 times (n+1).
// - Synchronous mode: rate is clock over 4 times (n+1), speed ignored.
// - Divisor held in separate high and low byte registers.
// - Default 8-bit using low byte; wide enable uses both bytes.
// - Writing either divisor byte clears the generator timer at once.
// - Formulas apply only when generating the clock; slave uses external clock.
`timescale 1ns/1ps
`include "sbrg_defines.svh"

module sbrg_top
  import sbrg_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       rx_i,
  output logic            rx_level_o,
  output logic            quarter_tick_o,
  output logic            bit_tick_o,
  output logic            bit_clk_o,
  output logic            bit_clk_oe_o
);

  sbrg_state_t st_ff;
  sbrg_state_t nxt_st;

  logic        sync_mode;
  logic        master;
  logic        high_speed;
  logic        port_enable;
  logic        wide_div;
  logic        generating;
  logic        div_write;
  logic [15:0] divisor;
  logic [4:0]  presc_len;
  logic        line;
  logic        rx_level;

  assign sync_mode   = st_ff.tx_ctrl[`SBRG_BIT_SYNC];
  assign master      = st_ff.tx_ctrl[`SBRG_BIT_MASTER];
  assign high_speed  = st_ff.tx_ctrl[`SBRG_BIT_HIGH_SPEED];
  assign port_enable = st_ff.rx_ctrl[`SBRG_BIT_PORT_ENABLE];
  assign wide_div    = st_ff.rate_ctrl[`SBRG_BIT_WIDE_DIV];

  // Slave synchronous operation takes its bit clock from the far end
  assign generating = port_enable & (~sync_mode | master);

  // High byte ignored in 8-bit mode
  assign divisor = wide_div ? {st_ff.div_high, st_ff.div_low}
                            : {8'h00, st_ff.div_low};

  assign div_write = wr_i & ((addr_i == `SBRG_OFF_DIV_HIGH) |
                             (addr_i == `SBRG_OFF_DIV_LOW));

  // Quarter-bit period is presc_len * (n + 1); a bit is four quarters
  always_comb
  begin
    presc_len = `SBRG_PRESC_DIV4;
    if (sync_mode)
    begin
      presc_len = `SBRG_PRESC_DIV4;
    end
    else if (!wide_div && !high_speed)
    begin
      presc_len = `SBRG_PRESC_DIV64;
    end
    else if (wide_div && !high_speed)
    begin
      presc_len = `SBRG_PRESC_DIV16;
    end
    else if (!wide_div && high_speed)
    begin
      presc_len = `SBRG_PRESC_DIV16;
    end
    else
    begin
      presc_len = `SBRG_PRESC_DIV4;
    end
  end

  // Polarity select only applies to the asynchronous data line
  assign line = rx_i ^ (st_ff.rate_ctrl[`SBRG_BIT_RX_INVERT] & ~sync_mode);

  always_comb
  begin
    nxt_st              = st_ff;
    nxt_st.rdata        = 8'h00;
    nxt_st.bit_tick     = 1'b0;
    nxt_st.quarter_tick = 1'b0;

    if (wr_i)
    begin
      case (addr_i)
        `SBRG_OFF_TX_CTRL:
        begin
          nxt_st.tx_ctrl = (wdata_i & `SBRG_WMASK_TX_CTRL) |
                           (`SBRG_RST_TX_CTRL & ~`SBRG_WMASK_TX_CTRL);
        end
        `SBRG_OFF_RX_CTRL:
        begin
          nxt_st.rx_ctrl = (wdata_i & `SBRG_WMASK_RX_CTRL) |
                           (`SBRG_RST_RX_CTRL & ~`SBRG_WMASK_RX_CTRL);
        end
        `SBRG_OFF_RATE_CTRL:
        begin
          nxt_st.rate_ctrl = (wdata_i & `SBRG_WMASK_RATE_CTRL) |
                             (`SBRG_RST_RATE_CTRL & ~`SBRG_WMASK_RATE_CTRL);
        end
        `SBRG_OFF_DIV_HIGH:
        begin
          nxt_st.div_high = wdata_i;
        end
        `SBRG_OFF_DIV_LOW:
        begin
          nxt_st.div_low = wdata_i;
        end
        default:
        begin
          nxt_st.tx_ctrl = st_ff.tx_ctrl;
        end
      endcase
    end

    if (rd_i)
    begin
      case (addr_i)
        `SBRG_OFF_TX_CTRL:
        begin
          nxt_st.rdata = st_ff.tx_ctrl;
        end
        `SBRG_OFF_RX_CTRL:
        begin
          nxt_st.rdata = st_ff.rx_ctrl;
        end
        `SBRG_OFF_RATE_CTRL:
        begin
          nxt_st.rdata = st_ff.rate_ctrl;
        end
        `SBRG_OFF_DIV_HIGH:
        begin
          nxt_st.rdata = st_ff.div_high;
        end
        `SBRG_OFF_DIV_LOW:
        begin
          nxt_st.rdata = st_ff.div_low;
        end
        `SBRG_OFF_GEN_STATUS:
        begin
          nxt_st.rdata = {4'h0, st_ff.phase, generating, rx_level};
        end
        default:
        begin
          nxt_st.rdata = 8'h00;
        end
      endcase
    end

    // Counting on every system clock edge makes the rate follow the clock
    if (!generating || div_write)
    begin
      nxt_st.presc = 5'h00;
      nxt_st.timer = 16'h0000;
      nxt_st.phase = 2'h0;
    end
    else if (st_ff.presc == presc_len - 5'h01)
    begin
      nxt_st.presc = 5'h00;
      if (st_ff.timer >= divisor)
      begin
        // >= covers a divisor narrowed by a mode change mid-count
        nxt_st.timer        = 16'h0000;
        nxt_st.quarter_tick = 1'b1;
        nxt_st.phase        = st_ff.phase + 2'h1;
        nxt_st.bit_tick     = (st_ff.phase == `SBRG_PHASE_DECIDE);
      end
      else
      begin
        nxt_st.timer = st_ff.timer + 16'h0001;
      end
    end
    else
    begin
      nxt_st.presc = st_ff.presc + 5'h01;
    end

    // Master bit clock: high for the first half bit, low for the second
    nxt_st.bit_clk_oe = port_enable & sync_mode & master;
    nxt_st.bit_clk    = port_enable & sync_mode & master &
                        ~nxt_st.phase[1];
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      st_ff <= '{tx_ctrl:      `SBRG_RST_TX_CTRL,
                 rx_ctrl:      `SBRG_RST_RX_CTRL,
                 rate_ctrl:    `SBRG_RST_RATE_CTRL,
                 div_high:     `SBRG_RST_DIV,
                 div_low:      `SBRG_RST_DIV,
                 presc:        5'h00,
                 timer:        16'h0000,
                 phase:        2'h0,
                 rdata:        8'h00,
                 bit_tick:     1'b0,
                 quarter_tick: 1'b0,
                 bit_clk:      1'b0,
                 bit_clk_oe:   1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Samples land on the quarter ticks ending phases 1, 2 and 3, from the bit centre to the bit tick
  sbrg_majority u_vote (
    .sys_clk_i  (sys_clk_i),
    .rstn_i     (rstn_i),
    .line_i     (line),
    .sample_a_i (st_ff.quarter_tick & (st_ff.phase == `SBRG_PHASE_DECIDE - 2'h1)),
    .sample_b_i (st_ff.quarter_tick & (st_ff.phase == `SBRG_PHASE_DECIDE)),
    .decide_i   (st_ff.bit_tick),
    .level_o    (rx_level)
  );

  assign rdata_o        = st_ff.rdata;
  assign rx_level_o     = rx_level;
  assign quarter_tick_o = st_ff.quarter_tick;
  assign bit_tick_o     = st_ff.bit_tick;
  assign bit_clk_o      = st_ff.bit_clk;
  assign bit_clk_oe_o   = st_ff.bit_clk_oe;

endmodule : sbrg_top

// ===== testbench/sbrg_checker.sv
`timescale 1ns/1ps
module sbrg_checker (
  input wire logic       sys_clk_i,
  input wire logic       rstn_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       rx_level_o,
  input wire logic       quarter_tick_o,
  input wire logic       bit_tick_o,
  input wire logic       bit_clk_o,
  input wire logic       bit_clk_oe_o
);
  logic en_ff;
  logic sync_ff;
  logic mst_ff;
  // Shadows of enable and mode bits, seen only through writes
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      en_ff   <= 1'b0;
      sync_ff <= 1'b0;
      mst_ff  <= 1'b0;
    end
    else
    begin
      if (wr_i && addr_i == 3'h1)
      begin
        en_ff <= wdata_i[7];
      end
      if (wr_i && addr_i == 3'h0)
      begin
        sync_ff <= wdata_i[4];
        mst_ff  <= wdata_i[7];
      end
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  unmapped_rd_a: assert property (rd_i && addr_i > 3'h5 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  tick_pair_a: assert property (bit_tick_o |-> quarter_tick_o)
    else $error("bit tick without quarter tick");
  bit_gap_a: assert property (bit_tick_o |=> !bit_tick_o [*3])
    else $error("bit ticks too close");
  oe_clk_a: assert property (!bit_clk_oe_o |-> !bit_clk_o)
    else $error("bit clock without enable");
  oe_mode_a: assert property (bit_clk_oe_o == $past(en_ff && sync_ff && mst_ff))
    else $error("bit clock enable does not follow mode");
  clk_phase_a: assert property (bit_tick_o && bit_clk_oe_o |-> bit_clk_o)
    else $error("bit clock low at bit start");
  clk_edge_a: assert property (bit_clk_oe_o && $fell(bit_clk_o) |-> quarter_tick_o)
    else $error("bit clock fell off a quarter tick");
  gen_off_a: assert property (!en_ff |=> !quarter_tick_o)
    else $error("tick while port disabled");
  clear_gap_a: assert property (wr_i && (addr_i == 3'h3 || addr_i == 3'h4)
    |-> ##2 !bit_tick_o [*3])
    else $error("timer not cleared by divisor write");
  vote_time_a: assert property ($changed(rx_level_o) |-> $past(bit_tick_o))
    else $error("level changed off the vote");
  cover property (bit_tick_o && bit_clk_oe_o);
  cover property ($fell(rx_level_o));
  cover property (rd_i && addr_i > 3'h5);
endmodule : sbrg_checker

bind sbrg_top sbrg_checker sbrg_checker_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .rx_level_o(rx_level_o), .quarter_tick_o(quarter_tick_o), .bit_tick_o(bit_tick_o),
  .bit_clk_o(bit_clk_o), .bit_clk_oe_o(bit_clk_oe_o));

// ===== testbench/sbrg_remote_tx.sv
`timescale 1ns/1ps
module sbrg_remote_tx (
  input  wire logic sys_clk_i,
  input  wire logic bit_tick_i,
  input  wire logic level_i,
  input  wire logic glitch_en_i,
  output logic      rx_o
);
  logic [1:0] pos_ff  = 2'h0;
  logic [1:0] slot_ff = 2'h0;
  // Glitch slot rotates so each sample point gets hit in turn
  always_ff @(posedge sys_clk_i)
  begin
    pos_ff  <= bit_tick_i ? 2'h0 : pos_ff + 2'h1;
    slot_ff <= slot_ff + {1'b0, bit_tick_i};
  end
  assign rx_o = level_i ^ (glitch_en_i && pos_ff == slot_ff);
endmodule : sbrg_remote_tx

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
  logic       sys_clk = 1'b0;
  logic       rstn    = 1'b0;
  logic [2:0] addr    = 3'h0;
  logic [7:0] wdata   = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic       lvl     = 1'b1;
  logic       glitch  = 1'b0;
  logic [7:0] rdata;
  logic       rx;
  logic       rx_level;
  logic       b_tick;
  logic       b_clk_oe;
  logic       q_tick;
  logic       b_clk;
  int         n_fail, num_checks, n, k, cycles;
  logic [2:0] w_a [5]   = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h4};
  logic [7:0] w_d [5]   = '{8'h00, 8'hff, 8'hff, 8'ha5, 8'h5a};
  logic [7:0] w_e [5]   = '{8'h02, 8'hfb, 8'hf8, 8'ha5, 8'h5a};
  logic [7:0] r_e [7]   = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [7:0] m_tx [6]  = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h90, 8'h94};
  logic [7:0] m_rc [6]  = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
  logic [7:0] m_hi [6]  = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h01, 8'h00};
  logic [7:0] m_lo [6]  = '{8'h02, 8'h02, 8'h02, 8'h09, 8'h03, 8'h03};
  int         m_exp [6] = '{192, 48, 4144, 40, 16, 16};

  sbrg_top sbrg_top_i (.sys_clk_i(sys_clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rx_i(rx), .rx_level_o(rx_level),
    .quarter_tick_o(q_tick), .bit_tick_o(b_tick), .bit_clk_o(b_clk), .bit_clk_oe_o(b_clk_oe));
  sbrg_remote_tx sbrg_remote_tx_i (.sys_clk_i(sys_clk), .bit_tick_i(b_tick),
    .level_i(lvl), .glitch_en_i(glitch), .rx_o(rx));

  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
    @(posedge sys_clk);
  endtask : wr_reg

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1 `CHK(rdata, e)
    @(posedge sys_clk);
  endtask : rd_chk

  // Counts edges up to the next bit tick, capped to avoid a hang
  task automatic wait_tick(output int c);
    c = 1;
    @(posedge sys_clk);
    while (b_tick !== 1'b1 && c < 20000)
    begin
      c++;
      @(posedge sys_clk);
    end
  endtask : wait_tick

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 7; i++)
      rd_chk(i[2:0], r_e[i]);
    wr_reg(3'h6, 8'hff);
    rd_chk(3'h6, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(w_a[i], w_d[i]);
      rd_chk(w_a[i], w_e[i]);
    end
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(3'h0, m_tx[i]);
      wr_reg(3'h2, m_rc[i]);
      wr_reg(3'h3, m_hi[i]);
      wr_reg(3'h4, m_lo[i]);
      wait_tick(n);
      wait_tick(n);
      `CHK(n, m_exp[i])
      `CHK(b_clk, (i >= 4))
    end
    `CHK(b_clk_oe, 1'b1)
    wr_reg(3'h0, 8'h10);
    k = 0;
    repeat (200) @(posedge sys_clk) k += int'(b_tick) + int'(q_tick) + int'(b_clk);
    `CHK(k, 0)
    `CHK(b_clk_oe, 1'b0)
    // Same divisor rewritten mid-bit: only the clear restarts a full bit
    wr_reg(3'h0, 8'h04);
    wr_reg(3'h2, 8'h08);
    wr_reg(3'h3, 8'h00);
    wr_reg(3'h4, 8'h63);
    wait_tick(n);
    repeat (200) @(posedge sys_clk);
    wr_reg(3'h4, 8'h63);
    wait_tick(n);
    `CHK(n, 400)
    wr_reg(3'h4, 8'h00);
    wr_reg(3'h0, 8'h04);
    wr_reg(3'h2, 8'h08);
    glitch <= 1'b1;
    for (int v = 0; v < 3; v++)
    begin
      if (v == 2)
        wr_reg(3'h2, 8'h28);
      lvl <= (v == 1);
      repeat (3) wait_tick(n);
      repeat (4)
      begin
        wait_tick(n);
        @(posedge sys_clk);
        #1 `CHK(rx_level, v != 0)
      end
    end
    report_and_stop();
  end
endmodule : tb_top
